// ---- design/dmcp_pkg.sv ----
// Package for the dual mode control port: constants, states and carriers
// Overview of operation
// RL1: Boot low: I2C slave; three latch lows select SPI
// RL2: Host latch pulses at least 20 ns each
// RL3: Boot high: no slave, EEPROM fetch instead
// RL4: Control word: chip byte, subaddress high/low, data
// RL5: I2C side is slave only, never starts
// RL6: I2C address 01110 plus select pins
// RL7: Address byte LSB one means host reads
// RL8: Eight bits MSB first, acknowledge on ninth
// RL9: Burst increments subaddress per decoded word width
// RL10: Stray start or stop returns to idle
// RL11: Host issues one start/stop per clock high
// RL12: Invalid subaddress gets no acknowledge, idle
// RL13: Read past top repeats highest location
// RL14: Write past top: discard, no acknowledge, idle
// RL15: Each written byte acknowledged on ninth clock
// RL16: Host reads via write subaddress, repeated start
// RL17: Host frames each SPI transaction with latch low
// RL18: SPI samples on rising, shifts on falling edge
// RL19: Host captures output on next falling edge
// RL20: SPI output floats except during reads
// RL21: Host sends SPI write data MSB first
// RL22: SPI chip address is low select pin
// RL23: SPI read drives output from fourth byte
// RL24: SPI mode sticks until reset
package dmcp_pkg;
    localparam logic [4:0] I2C_ADDR_PREFIX = 5'h0E;
    localparam logic [5:0] SPI_ADDR_PREFIX = 6'h00;
    localparam logic [1:0] LATCH_PULSES_TO_SPI = 2'h3;
    localparam logic [15:0] SUBADDR_TOP = 16'hFFFF;
    localparam logic [15:0] SUBADDR_INVALID_LO = 16'hF000;
    localparam logic [15:0] SUBADDR_INVALID_HI = 16'hF7FF;
    localparam logic [2:0] BYTE_CHIP = 3'h0;
    localparam logic [2:0] BYTE_SUB_HI = 3'h1;
    localparam logic [2:0] BYTE_SUB_LO = 3'h2;
    localparam logic [2:0] BYTE_DATA = 3'h3;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_START = 4'hF;
    localparam logic [3:0] STRAP_SETTLE = 4'h2;
    localparam logic [15:0] SUBADDR_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        DMCP_IDLE = 3'h0,
        DMCP_ADDR = 3'h1,
        DMCP_RX = 3'h3,
        DMCP_TX = 3'h2,
        DMCP_BOOT = 3'h6
    } dmcp_state_e;

    typedef enum logic [1:0] {
        DMCP_MODE_I2C = 2'h0,
        DMCP_MODE_SPI = 2'h1,
        DMCP_MODE_BOOT = 2'h3
    } dmcp_mode_e;

    // Memory side request toward the device core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [2:0] byte_idx;
    } dmcp_mem_req_s;

    typedef struct packed {
        dmcp_state_e st;
        dmcp_mode_e mode;
        logic boot_seen;
        logic [1:0] latch_cnt;
        logic [2:0] sync_scl;
        logic [2:0] sync_sda;
        logic [2:0] sync_lat;
        logic [2:0] sync_din;
        logic [1:0] sync_a0;
        logic [1:0] sync_a1;
        logic [1:0] sync_boot;
        logic [3:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [2:0] word_pos;
        logic [7:0] shreg;
        logic [7:0] txreg;
        logic rnw;
        logic [15:0] subaddr;
        logic at_top;
        logic sda_oe_b;
        logic dout;
        logic dout_oe_b;
        logic boot_req;
        dmcp_mem_req_s req;
    } dmcp_state_s;
endpackage

// ---- design/dmcp_top.sv ----
// Dual mode control port: I2C slave or latch-selected SPI slave
module dmcp_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic boot_source_select,
    input wire logic addr_select_low,
    input wire logic addr_select_high,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic spi_latch_n,
    input wire logic spi_data_in,
    output logic spi_data_out,
    output logic spi_data_out_oe_b,
    input wire logic [7:0] mem_rdata,
    input wire logic [2:0] mem_width,
    output dmcp_pkg::dmcp_mem_req_s mem_req,
    output logic boot_request,
    output logic spi_mode
);
    logic [1:0] rst_sync_q;
    logic rst_n_int;
    dmcp_pkg::dmcp_state_s s_q;
    dmcp_pkg::dmcp_state_s s_d;

    // Subaddress validity check
    function automatic logic sub_valid(input logic [15:0] a);
        sub_valid = !(a >= dmcp_pkg::SUBADDR_INVALID_LO && a <= dmcp_pkg::SUBADDR_INVALID_HI);
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_q[1];

    always_comb begin
        logic scl_r;
        logic scl_f;
        logic sda_r;
        logic sda_f;
        logic scl_h;
        logic lat_f;
        logic lat_r;
        logic lat_l;
        logic clk_r;
        logic clk_f;
        logic din;
        logic [7:0] byte_v;
        logic [2:0] wid;
        logic [15:0] chip_i2c;
        logic [6:0] chip_spi;
        s_d = s_q;
        s_d.req.wr = 1'b0;
        s_d.req.rd = 1'b0;
        s_d.sync_scl = {s_q.sync_scl[1:0], scl_in};
        s_d.sync_sda = {s_q.sync_sda[1:0], sda_in};
        s_d.sync_lat = {s_q.sync_lat[1:0], spi_latch_n};
        s_d.sync_din = {s_q.sync_din[1:0], spi_data_in};
        s_d.sync_a0 = {s_q.sync_a0[0], addr_select_low};
        s_d.sync_a1 = {s_q.sync_a1[0], addr_select_high};
        s_d.sync_boot = {s_q.sync_boot[0], boot_source_select};
        scl_h = s_q.sync_scl[1];
        scl_r = s_q.sync_scl[1] && !s_q.sync_scl[2];
        scl_f = !s_q.sync_scl[1] && s_q.sync_scl[2];
        sda_r = s_q.sync_sda[1] && !s_q.sync_sda[2];
        sda_f = !s_q.sync_sda[1] && s_q.sync_sda[2];
        lat_f = !s_q.sync_lat[1] && s_q.sync_lat[2];
        lat_r = s_q.sync_lat[1] && !s_q.sync_lat[2];
        lat_l = !s_q.sync_lat[1];
        clk_r = scl_r;
        clk_f = scl_f;
        din = (s_q.mode == dmcp_pkg::DMCP_MODE_SPI) ? s_q.sync_din[1] : s_q.sync_sda[1];
        byte_v = {s_q.shreg[6:0], din};
        wid = (mem_width == 3'h0) ? 3'h1 : mem_width;
        chip_i2c = {8'h00, dmcp_pkg::I2C_ADDR_PREFIX, s_q.sync_a1[1], s_q.sync_a0[1], 1'b0};
        chip_spi = {dmcp_pkg::SPI_ADDR_PREFIX, s_q.sync_a0[1]};

        // Strap caught once after reset release
        if (!s_q.boot_seen) begin
            // Wait for the strap synchroniser to fill
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            if (s_q.bit_cnt == dmcp_pkg::STRAP_SETTLE) begin
                s_d.boot_seen = 1'b1;
                s_d.bit_cnt = 4'h0;
                if (s_q.sync_boot[1]) begin
                    s_d.mode = dmcp_pkg::DMCP_MODE_BOOT; // [RL3]
                    s_d.st = dmcp_pkg::DMCP_BOOT;
                    s_d.boot_req = 1'b1;
                end
            end
        end else if (s_q.mode == dmcp_pkg::DMCP_MODE_BOOT) begin
            s_d.st = dmcp_pkg::DMCP_BOOT; // [RL3] [RL5]
        end else if (s_q.mode == dmcp_pkg::DMCP_MODE_I2C) begin
            // Latch low pulses count toward SPI entry; sticky until reset
            if (lat_f) begin
                s_d.latch_cnt = s_q.latch_cnt + 2'h1; // [RL1] [RL24]
                if (s_q.latch_cnt == dmcp_pkg::LATCH_PULSES_TO_SPI - 2'h1) begin
                    s_d.mode = dmcp_pkg::DMCP_MODE_SPI; // [RL1] [RL24]
                    s_d.st = dmcp_pkg::DMCP_IDLE;
                    s_d.sda_oe_b = 1'b1;
                end
            end
            // Read byte arrives the cycle after its request
            if (s_q.st == dmcp_pkg::DMCP_TX && s_q.req.rd) begin
                s_d.txreg = mem_rdata;
                s_d.sda_oe_b = mem_rdata[7];
            end
            if (scl_h && (sda_f || sda_r)) begin
                // Start or stop anywhere restarts or idles the slave
                s_d.sda_oe_b = 1'b1; // [RL10]
                // Clock fall closing a start is not a data bit
                s_d.bit_cnt = sda_f ? dmcp_pkg::BIT_START : 4'h0;
                s_d.st = sda_f ? dmcp_pkg::DMCP_ADDR : dmcp_pkg::DMCP_IDLE; // [RL10]
                if (sda_f) begin
                    s_d.byte_cnt = dmcp_pkg::BYTE_CHIP;
                end
            end else if (s_q.st != dmcp_pkg::DMCP_IDLE && clk_r) begin
                if (s_q.bit_cnt == dmcp_pkg::BIT_ACK) begin
                    if (s_q.st == dmcp_pkg::DMCP_TX && s_q.sync_sda[1]) begin
                        s_d.st = dmcp_pkg::DMCP_IDLE; // [RL13]
                    end
                end else begin
                    s_d.shreg = byte_v; // [RL8]
                end
            end else if (s_q.st != dmcp_pkg::DMCP_IDLE && clk_f) begin
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                s_d.sda_oe_b = 1'b1;
                if (s_q.bit_cnt == 4'h7) begin
                    case (s_q.st)
                        dmcp_pkg::DMCP_ADDR: begin
                            if (s_q.shreg[7:1] == chip_i2c[7:1]) begin
                                s_d.sda_oe_b = 1'b0; // [RL6] [RL8]
                                s_d.rnw = s_q.shreg[0]; // [RL7]
                                s_d.st = s_q.shreg[0] ? dmcp_pkg::DMCP_TX : dmcp_pkg::DMCP_RX;
                                s_d.byte_cnt = s_q.shreg[0] ? dmcp_pkg::BYTE_DATA
                                                            : dmcp_pkg::BYTE_SUB_HI; // [RL4]
                            end else begin
                                s_d.st = dmcp_pkg::DMCP_IDLE; // [RL8]
                            end
                        end
                        dmcp_pkg::DMCP_RX: begin
                            if (s_q.byte_cnt == dmcp_pkg::BYTE_SUB_HI) begin
                                s_d.subaddr[15:8] = s_q.shreg; // [RL4]
                                s_d.byte_cnt = dmcp_pkg::BYTE_SUB_LO;
                                s_d.sda_oe_b = 1'b0;
                            end else if (s_q.byte_cnt == dmcp_pkg::BYTE_SUB_LO) begin
                                s_d.subaddr[7:0] = s_q.shreg;
                                s_d.byte_cnt = dmcp_pkg::BYTE_DATA;
                                s_d.word_pos = 3'h0;
                                s_d.at_top = 1'b0;
                                if (sub_valid({s_q.subaddr[15:8], s_q.shreg})) begin
                                    s_d.sda_oe_b = 1'b0;
                                end else begin
                                    s_d.st = dmcp_pkg::DMCP_IDLE; // [RL12]
                                end
                            end else if (s_q.at_top) begin
                                s_d.st = dmcp_pkg::DMCP_IDLE; // [RL14]
                            end else begin
                                s_d.sda_oe_b = 1'b0; // [RL15]
                                s_d.req.wr = 1'b1;
                                s_d.req.addr = s_q.subaddr;
                                s_d.req.wdata = s_q.shreg;
                                s_d.req.byte_idx = s_q.word_pos;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (s_q.bit_cnt == dmcp_pkg::BIT_ACK) begin
                    s_d.bit_cnt = 4'h0;
                    if (s_q.st == dmcp_pkg::DMCP_TX) begin
                        s_d.req.rd = 1'b1;
                        s_d.req.addr = s_q.subaddr;
                        s_d.req.byte_idx = s_q.word_pos;
                    end
                end else if (s_q.st == dmcp_pkg::DMCP_TX) begin
                    s_d.txreg = {s_q.txreg[6:0], 1'b0};
                    s_d.sda_oe_b = s_q.txreg[6];
                end
            end
        end else begin
            // SPI mode: frame is latch low
            if (!lat_l || lat_f) begin
                s_d.st = dmcp_pkg::DMCP_IDLE;
                s_d.bit_cnt = 4'h0;
                s_d.byte_cnt = dmcp_pkg::BYTE_CHIP;
                s_d.word_pos = 3'h0;
                s_d.dout_oe_b = 1'b1; // [RL20]
                if (lat_f) begin
                    s_d.st = dmcp_pkg::DMCP_RX;
                end
            end else if (s_q.st != dmcp_pkg::DMCP_IDLE && clk_r) begin
                s_d.shreg = byte_v; // [RL18] [RL21]
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                if (s_q.bit_cnt == 4'h7) begin
                    s_d.bit_cnt = 4'h0;
                    case (s_q.byte_cnt)
                        dmcp_pkg::BYTE_CHIP: begin
                            s_d.rnw = byte_v[0]; // [RL7]
                            s_d.byte_cnt = dmcp_pkg::BYTE_SUB_HI;
                            if (byte_v[7:1] != chip_spi) begin
                                s_d.st = dmcp_pkg::DMCP_IDLE; // [RL22]
                            end
                        end
                        dmcp_pkg::BYTE_SUB_HI: begin
                            s_d.subaddr[15:8] = byte_v;
                            s_d.byte_cnt = dmcp_pkg::BYTE_SUB_LO;
                        end
                        dmcp_pkg::BYTE_SUB_LO: begin
                            s_d.subaddr[7:0] = byte_v; // [RL4]
                            s_d.byte_cnt = dmcp_pkg::BYTE_DATA;
                            if (s_q.rnw) begin
                                s_d.st = dmcp_pkg::DMCP_TX;
                                s_d.req.rd = 1'b1;
                                s_d.req.addr = {s_q.subaddr[15:8], byte_v};
                                s_d.req.byte_idx = 3'h0;
                            end
                        end
                        default: begin
                            if (s_q.rnw) begin
                                s_d.req.rd = 1'b1;
                                s_d.req.addr = s_q.subaddr;
                                s_d.req.byte_idx = s_q.word_pos;
                            end else begin
                                s_d.req.wr = 1'b1;
                                s_d.req.addr = s_q.subaddr;
                                s_d.req.wdata = byte_v;
                                s_d.req.byte_idx = s_q.word_pos;
                            end
                        end
                    endcase
                end
            end else if (s_q.st == dmcp_pkg::DMCP_TX && clk_f) begin
                if (s_q.bit_cnt == 4'h0) begin
                    s_d.dout_oe_b = 1'b0; // [RL23]
                    s_d.txreg = {mem_rdata[6:0], 1'b0};
                    s_d.dout = mem_rdata[7]; // [RL18]
                end else begin
                    s_d.dout = s_q.txreg[7];
                    s_d.txreg = {s_q.txreg[6:0], 1'b0};
                end
            end
        end
        // Word position advances once the addressed width is known
        if (s_q.mode != dmcp_pkg::DMCP_MODE_BOOT && (s_q.req.wr || s_q.req.rd)) begin
            s_d.word_pos = s_q.word_pos + 3'h1;
            if (s_q.word_pos + 3'h1 >= wid) begin
                s_d.word_pos = 3'h0; // [RL9]
                if (s_q.subaddr != dmcp_pkg::SUBADDR_TOP) begin
                    s_d.subaddr = s_q.subaddr + 16'h0001; // [RL13]
                end else if (s_q.req.wr) begin
                    s_d.at_top = 1'b1; // [RL14]
                end
            end
        end
        if (lat_r) begin
            s_d.latch_cnt = s_d.latch_cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            s_q <= '{st: dmcp_pkg::DMCP_IDLE, mode: dmcp_pkg::DMCP_MODE_I2C,
                     sync_scl: 3'h7, sync_sda: 3'h7, sync_lat: 3'h7,
                     subaddr: dmcp_pkg::SUBADDR_RESET, sda_oe_b: 1'b1,
                     dout_oe_b: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_b = s_q.sda_oe_b;
    assign spi_data_out = s_q.dout;
    assign spi_data_out_oe_b = s_q.dout_oe_b;
    assign mem_req = s_q.req;
    assign boot_request = s_q.boot_req;
    assign spi_mode = (s_q.mode == dmcp_pkg::DMCP_MODE_SPI);
endmodule

// ---- tb/dmcp_monitor.sv ----
// Checker for the dual mode control port pins
module dmcp_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_b,
    input wire logic spi_latch_n,
    input wire logic spi_data_out_oe_b,
    input wire dmcp_pkg::dmcp_mem_req_s mem_req,
    input wire logic boot_request,
    input wire logic spi_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda output level not low");
    a_ack_scl_low: assert property ($fell(sda_oe_b) |-> !scl_in)
        else $error("sda pulled low while clock high");
    a_release_scl_low: assert property ($rose(sda_oe_b) |-> !scl_in)
        else $error("sda released while clock high");
    a_spi_out_quiet: assert property (!spi_mode |-> spi_data_out_oe_b)
        else $error("serial output driven outside spi mode");
    a_spi_no_sda: assert property (spi_mode |-> sda_oe_b)
        else $error("sda pulled in spi mode");
    a_boot_silent: assert property (boot_request |-> sda_oe_b && spi_data_out_oe_b && !spi_mode)
        else $error("port active during eeprom boot");
    a_mode_sticks: assert property (spi_mode |=> spi_mode)
        else $error("spi mode dropped without reset");
    a_wr_single: assert property (mem_req.wr |=> !mem_req.wr)
        else $error("write strobe longer than one cycle");
    a_wr_rd_apart: assert property (!(mem_req.wr && mem_req.rd))
        else $error("read and write strobes together");
    a_latch_release: assert property ((spi_mode && spi_latch_n) [*8] |-> spi_data_out_oe_b)
        else $error("serial output driven after latch high");
endmodule

// ---- tb/dmcp_host_model.sv ----
// Host model: I2C master and SPI master on the control port pins
module dmcp_host_model (
    input wire logic clk,
    input wire logic sda_wire,
    input wire logic spi_data_out,
    output logic scl,
    output logic sda_h,
    output logic latch_n,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
        latch_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        sda_h = 1'b1;
        w(4);
        scl = 1'b1;
        w(4);
        sda_h = 1'b0;
        w(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        w(2);
        sda_h = 1'b0;
        w(4);
        scl = 1'b1;
        w(4);
        sda_h = 1'b1;
        w(4);
    endtask
    // One 160 ns clock: data set while low, wire read midway through the high phase
    task automatic bit_x(input logic b, output logic r);
        w(2);
        sda_h = b;
        w(4);
        scl = 1'b1;
        w(1);
        r = sda_wire;
        w(1);
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask
    task automatic lat(input logic v);
        latch_n = v;
        w(4);
    endtask
    task automatic sbyte(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sdi = d[i];
            w(3);
            scl = 1'b1;
            w(3);
            q[i] = spi_data_out;
            scl = 1'b0;
            w(2);
        end
        sdi = ~sdi;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Testbench for the dual mode control port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DEV = 8'h76;
    logic clk = 1'b0;
    logic rst_b;
    logic boot;
    logic a0;
    logic a1;
    logic scl, sda_h, lat_n, sdi, sda_out, sda_oe_b, dout, dout_oe_b, boot_req, spi_mode;
    logic [7:0] mem_rdata;
    logic [2:0] mem_width;
    dmcp_pkg::dmcp_mem_req_s mem_req;
    logic [26:0] wq[$];
    int num_errors = 0;
    int check_count = 0;
    wire sda = sda_h & (sda_oe_b | sda_out);
    always #10 clk = ~clk;
    function automatic logic [7:0] fdat(input logic [15:0] a, input logic [2:0] i);
        return a[7:0] ^ a[15:8] ^ {5'h00, i} ^ 8'h5A;
    endfunction
    assign mem_rdata = fdat(mem_req.addr, mem_req.byte_idx);
    assign mem_width = (mem_req.addr >= 16'hFF00) ? 3'h1 : 3'h2;
    dmcp_top uut (.clk(clk), .rst_b(rst_b), .boot_source_select(boot), .addr_select_low(a0),
        .addr_select_high(a1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_b(sda_oe_b), .spi_latch_n(lat_n), .spi_data_in(sdi), .spi_data_out(dout),
        .spi_data_out_oe_b(dout_oe_b), .mem_rdata(mem_rdata), .mem_width(mem_width),
        .mem_req(mem_req), .boot_request(boot_req), .spi_mode(spi_mode));
    dmcp_host_model host (.clk(clk), .sda_wire(sda), .spi_data_out(dout), .scl(scl),
        .sda_h(sda_h), .latch_n(lat_n), .sdi(sdi));
    always @(posedge clk) if (mem_req.wr) wq.push_back({mem_req.addr, mem_req.byte_idx, mem_req.wdata});
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic do_reset(input logic b);
        rst_b = 1'b0;
        boot = b;
        host.w(3);
        rst_b = 1'b1;
        host.w(8);
    endtask
    task automatic ihead(input logic [7:0] c, input logic [15:0] s, output logic [2:0] k);
        host.start();
        host.wbyte(c, k[2]);
        host.wbyte(s[15:8], k[1]);
        host.wbyte(s[7:0], k[0]);
    endtask
    task automatic sfr(input logic [7:0] c, input logic [15:0] s, input logic [7:0] d,
        output logic [7:0] q);
        host.lat(1'b0);
        host.sbyte(c, q);
        host.sbyte(s[15:8], q);
        chk("oe_early", 1, dout_oe_b);
        host.sbyte(s[7:0], q);
        host.sbyte(d, q);
        chk("oe_data", {31'h0, !c[0]}, dout_oe_b);
        host.lat(1'b1);
        host.w(6);
        chk("oe_after", 1, dout_oe_b);
    endtask
    initial begin
        logic [2:0] k;
        logic ak;
        logic [7:0] q, d;
        logic [15:0] s;
        void'($urandom(39591));
        a0 = 1'b0;
        a1 = 1'b0;
        do_reset(1'b0);
        chk("spi_mode", 0, spi_mode);
        chk("boot_request", 0, boot_req);
        for (int j = 0; j < 4; j++) begin
            a1 = j[1];
            a0 = j[0];
            d = 8'h70 | {5'h00, j[1:0], 1'b0};
            ihead(d, 16'h0000, k);
            chk("ack_match", 3'h7, k);
            host.stop();
            host.start();
            host.wbyte(d ^ (8'h02 << ($urandom % 7)), ak);
            chk("ack_other", 0, ak);
            host.stop();
        end
        $display("test address done");
        wq.delete();
        s = 16'($urandom) & 16'h7FFE;
        ihead(DEV, s, k);
        for (int j = 0; j < 4; j++) begin
            d = 8'($urandom);
            host.wbyte(d, ak);
            chk("data_ack", 1, ak);
            chk("write", {s + 16'(j / 2), 3'(j % 2), d}, (wq.size() == 1) ? wq.pop_front() : 27'h0);
        end
        host.stop();
        ihead(DEV, 16'hF000 | 16'($urandom % 2048), k);
        chk("bad_sub", 3'h6, k);
        host.stop();
        ihead(DEV, 16'hFFFF, k);
        host.wbyte(8'hC3, ak);
        host.wbyte(8'h3C, ak);
        chk("past_top_ack", 0, ak);
        chk("past_top_wr", 1, wq.size());
        host.stop();
        host.start();
        host.wbyte(DEV, ak);
        host.wbyte(8'h12, ak);
        host.stop();
        host.start();
        host.wbyte(8'h34, ak);
        chk("after_stray_stop", 0, ak);
        host.stop();
        ihead(DEV, 16'hFFFE, k);
        host.start();
        host.wbyte(DEV | 8'h01, ak);
        chk("read_ack", 1, ak);
        for (int j = 0; j < 3; j++) begin
            host.rbyte(j == 2, q);
            chk("read", fdat((j == 0) ? 16'hFFFE : 16'hFFFF, 3'h0), q);
        end
        host.stop();
        $display("test i2c done");
        for (int j = 0; j < 3; j++) begin
            chk("mode_early", 0, spi_mode);
            host.lat(1'b0);
            host.lat(1'b1);
        end
        chk("mode_spi", 1, spi_mode);
        host.scl = 1'b0;
        wq.delete();
        sfr(8'h02, 16'h1234, d, q);
        chk("spi_wr", {16'h1234, 3'h0, d}, (wq.size() == 1) ? wq.pop_front() : 27'h0);
        sfr(8'h00, 16'h1234, d, q);
        chk("spi_other_chip", 0, wq.size());
        sfr(8'h03, 16'h4321, 8'h00, q);
        chk("spi_rd", fdat(16'h4321, 3'h0), q);
        $display("test spi done");
        do_reset(1'b1);
        chk("boot_request", 1, boot_req);
        chk("spi_mode_reset", 0, spi_mode);
        host.start();
        host.wbyte(DEV, ak);
        chk("boot_ack", 0, ak);
        host.stop();
        $display("test boot done");
        stop_test();
    end
    initial begin
        #1000000;
        num_errors++;
        stop_test();
    end
endmodule
bind dmcp_top dmcp_monitor mon (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_b(sda_oe_b), .spi_latch_n(spi_latch_n), .spi_data_out_oe_b(spi_data_out_oe_b),
    .mem_req(mem_req), .boot_request(boot_request), .spi_mode(spi_mode));
